// ===== ebt_bus_timing.sv
`timescale 1ns/1ps
`default_nettype none


module ebt_bus_timing (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  // register bus write address and data
  input  wire logic [3:0]  i_axi_awaddr,
  input  wire logic        i_axi_awvalid,
  output var  logic        o_axi_awready,
  input  wire logic [31:0] i_axi_wdata,
  input  wire logic [3:0]  i_axi_wstrb,
  input  wire logic        i_axi_wvalid,
  output var  logic        o_axi_wready,
  // register bus write response
  output var  logic [1:0]  o_axi_bresp,
  output var  logic        o_axi_bvalid,
  input  wire logic        i_axi_bready,
  // register bus read
  input  wire logic [3:0]  i_axi_araddr,
  input  wire logic        i_axi_arvalid,
  output var  logic        o_axi_arready,
  output var  logic [31:0] o_axi_rdata,
  output var  logic [1:0]  o_axi_rresp,
  output var  logic        o_axi_rvalid,
  input  wire logic        i_axi_rready,
  // bus cycle requests from the core
  input  wire logic        i_req_valid,
  output var  logic        o_req_ready,
  input  wire logic [1:0]  i_req_kind,
  input  wire logic        i_req_latched,
  input  wire logic        i_req_split,
  input  wire logic        i_req_wr_lo,
  input  wire logic        i_req_wr_hi,
  output var  logic        o_cycle_done,
  // external bus pins
  input  wire logic        i_wait,
  output var  logic        o_addr_latch,
  output var  logic        o_code_fetch_strobe_n,
  output var  logic        o_read_strobe_n,
  output var  logic        o_write_strobe_low_n,
  output var  logic        o_write_strobe_high_n,
  output var  logic        o_wdata_oe_n,
  output var  logic        o_addr_a0
);

  logic                rst_n;
  logic                wait_s;
  logic [7:0]          btl_ff;
  logic [7:0]          bth_ff;
  logic                aw_got_ff;
  logic                w_got_ff;
  logic [3:0]          awaddr_ff;
  logic [31:0]         wdata_ff;
  logic                wstrb0_ff;
  ebt_pkg::ebt_state_e st_ff;
  ebt_pkg::ebt_state_e nxt_st;
  logic [2:0]          cnt_ff, nxt_cnt;
  logic [2:0]          len_ff, nxt_len;
  logic [2:0]          sbeg_ff, nxt_sbeg;
  logic [2:0]          send_ff, nxt_send;
  logic [2:0]          dbeg_ff, nxt_dbeg;
  logic [2:0]          alast_ff, nxt_alast;
  logic                ale_cyc_ff, nxt_ale_cyc;
  logic                second_ff, nxt_second;
  logic                pend_ff, nxt_pend;
  logic                nxt_done;
  logic [1:0]          kind_ff;
  logic                lat_ff, split_ff, wr_lo_ff, wr_hi_ff;
  logic                stall_ff;
  logic                ale_ff;
  logic                ale_cut_neg_ff;
  logic                take, stall, strobe_win;
  logic [2:0]          wait_pt;
  logic [1:0]          unl_code, lat_code, unl_read, lat_read, unl_write, lat_write;
  logic                latch_width_sel, whs, wws;

  //////////////////////////////////////////////////////////////////////////////
  // reset release and wait pin synchronisers
  ebt_sync #(.RST_VAL(1'b0)) u_rst_sync (
    .i_clk  (i_sys_clk),
    .i_rstn (i_rstn),
    .i_d    (1'b1),
    .o_q    (rst_n)
  );

  ebt_sync #(.RST_VAL(1'b0)) u_wait_sync (
    .i_clk  (i_sys_clk),
    .i_rstn (rst_n),
    .i_d    (i_wait),
    .o_q    (wait_s)
  );

  assign unl_code  = btl_ff[ebt_pkg::FLD_UNL_CODE_LSB +: 2];
  assign lat_code  = btl_ff[ebt_pkg::FLD_LAT_CODE_LSB +: 2];
  assign latch_width_sel      = btl_ff[ebt_pkg::FLD_LATCH_WIDTH_BIT];
  assign whs       = btl_ff[ebt_pkg::FLD_WRITE_HOLD_BIT];
  assign wws       = btl_ff[ebt_pkg::FLD_WRITE_WIDTH_BIT];
  assign unl_write = bth_ff[ebt_pkg::FLD_UNL_WRITE_LSB +: 2];
  assign lat_write = bth_ff[ebt_pkg::FLD_LAT_WRITE_LSB +: 2];
  assign unl_read  = bth_ff[ebt_pkg::FLD_UNL_READ_LSB +: 2];
  assign lat_read  = bth_ff[ebt_pkg::FLD_LAT_READ_LSB +: 2];

  //////////////////////////////////////////////////////////////////////////////
  // register bus: write channel, address and data taken in either order
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_axi_awready <= 1'b1;
      o_axi_wready  <= 1'b1;
      o_axi_bvalid  <= 1'b0;
      o_axi_bresp   <= ebt_pkg::RESP_OKAY;
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      awaddr_ff     <= 4'h0;
      wdata_ff      <= 32'h0;
      wstrb0_ff     <= 1'b0;
    end else begin
      if (i_axi_awvalid && o_axi_awready) begin
        o_axi_awready <= 1'b0;
        aw_got_ff     <= 1'b1;
        awaddr_ff     <= i_axi_awaddr;
      end
      if (i_axi_wvalid && o_axi_wready) begin
        o_axi_wready <= 1'b0;
        w_got_ff     <= 1'b1;
        wdata_ff     <= i_axi_wdata;
        wstrb0_ff    <= i_axi_wstrb[0];
      end
      if (aw_got_ff && w_got_ff) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        o_axi_bvalid <= 1'b1;
        o_axi_bresp  <= (awaddr_ff == ebt_pkg::REG_TIMING_LOW_OFF ||
                         awaddr_ff == ebt_pkg::REG_TIMING_HIGH_OFF ||
                         awaddr_ff == ebt_pkg::REG_STATUS_OFF) ? ebt_pkg::RESP_OKAY : ebt_pkg::RESP_SLVERR;
      end
      // ready comes back only after the response, so one write at a time
      if (o_axi_bvalid && i_axi_bready) begin
        o_axi_bvalid  <= 1'b0;
        o_axi_awready <= 1'b1;
        o_axi_wready  <= 1'b1;
      end
    end
  end

  // timing registers; a cycle in flight keeps its sampled values, except a split read's second byte, which reads unl_read then
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      btl_ff <= ebt_pkg::TIMING_LOW_RST;
      bth_ff <= ebt_pkg::TIMING_HIGH_RST;
    end else if (aw_got_ff && w_got_ff && wstrb0_ff) begin
      if (awaddr_ff == ebt_pkg::REG_TIMING_LOW_OFF) btl_ff <= {1'b0, wdata_ff[6:0]};
      if (awaddr_ff == ebt_pkg::REG_TIMING_HIGH_OFF) bth_ff <= wdata_ff[7:0];
    end
  end

  // register bus: read channel
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_axi_arready <= 1'b1;
      o_axi_rvalid  <= 1'b0;
      o_axi_rdata   <= 32'h0;
      o_axi_rresp   <= ebt_pkg::RESP_OKAY;
    end else if (i_axi_arvalid && o_axi_arready) begin
      o_axi_arready <= 1'b0;
      o_axi_rvalid  <= 1'b1;
      o_axi_rresp   <= ebt_pkg::RESP_OKAY;
      case (i_axi_araddr)
        ebt_pkg::REG_TIMING_LOW_OFF:  o_axi_rdata <= {24'h0, btl_ff};
        ebt_pkg::REG_TIMING_HIGH_OFF: o_axi_rdata <= {24'h0, bth_ff};
        ebt_pkg::REG_STATUS_OFF: begin
          o_axi_rdata <= {25'h0, cnt_ff, 1'b0, second_ff, stall_ff, st_ff != ebt_pkg::EBT_IDLE};
        end
        default: begin
          o_axi_rdata <= 32'h0;
          o_axi_rresp <= ebt_pkg::RESP_SLVERR;
        end
      endcase
    end else if (o_axi_rvalid && i_axi_rready) begin
      o_axi_rvalid  <= 1'b0;
      o_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // request capture
  assign take = i_req_valid && o_req_ready;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      kind_ff  <= ebt_pkg::KIND_CODE;
      lat_ff   <= 1'b0;
      split_ff <= 1'b0;
      wr_lo_ff <= 1'b0;
      wr_hi_ff <= 1'b0;
    end else if (take) begin
      kind_ff  <= i_req_kind;
      lat_ff   <= i_req_latched;
      split_ff <= i_req_split && (i_req_kind == ebt_pkg::KIND_READ);
      wr_lo_ff <= i_req_wr_lo;
      wr_hi_ff <= i_req_wr_hi;
    end
  end

  // wait holds the counter at the sample point; a one clock read never reaches it
  assign wait_pt = (kind_ff == ebt_pkg::KIND_READ) ? send_ff - ebt_pkg::RD_WAIT_LEAD
                                                   : send_ff - ebt_pkg::WAIT_LEAD;
  assign stall   = (st_ff == ebt_pkg::EBT_RUN) && wait_s && (cnt_ff >= sbeg_ff) && (cnt_ff == wait_pt);

  //////////////////////////////////////////////////////////////////////////////
  // cycle sequencer; no clipping of bad settings, software keeps them sane
  always_comb begin
    nxt_st      = st_ff;
    nxt_cnt     = cnt_ff;
    nxt_len     = len_ff;
    nxt_sbeg    = sbeg_ff;
    nxt_send    = send_ff;
    nxt_dbeg    = dbeg_ff;
    nxt_alast   = alast_ff;
    nxt_ale_cyc = ale_cyc_ff;
    nxt_second  = second_ff;
    nxt_pend    = pend_ff;
    nxt_done    = 1'b0;
    case (st_ff)
      ebt_pkg::EBT_IDLE: begin
        if (take) nxt_st = ebt_pkg::EBT_SETUP;
      end
      ebt_pkg::EBT_SETUP: begin
        nxt_st      = ebt_pkg::EBT_RUN;
        nxt_cnt     = 3'h0;
        nxt_second  = 1'b0;
        nxt_pend    = split_ff;
        nxt_ale_cyc = lat_ff || split_ff;
        nxt_alast   = latch_width_sel ? ebt_pkg::ALE_LAST_WIDE : ebt_pkg::ALE_LAST_NARROW;
        nxt_dbeg    = 3'h0;
        case (kind_ff)
          ebt_pkg::KIND_CODE: begin
            nxt_len  = nxt_ale_cyc ? ebt_pkg::LAT_BASE_CLKS + {1'b0, lat_code}
                                   : ebt_pkg::UNL_BASE_CLKS + {1'b0, unl_code};
            nxt_sbeg = nxt_ale_cyc ? nxt_alast + 3'h1 : 3'h0;
            nxt_send = nxt_len;
          end
          ebt_pkg::KIND_WRITE: begin
            nxt_len  = nxt_ale_cyc ? ebt_pkg::LAT_BASE_CLKS + {1'b0, lat_write}
                                   : ebt_pkg::UNL_WRITE_BASE_CLKS + {1'b0, unl_write};
            nxt_send = nxt_len - (whs ? ebt_pkg::WR_HOLD_ON : ebt_pkg::WR_HOLD_OFF);
            nxt_sbeg = nxt_send - (wws ? ebt_pkg::WR_WIDTH_WIDE : ebt_pkg::WR_WIDTH_NARROW);
            nxt_dbeg = nxt_ale_cyc ? nxt_alast + 3'h1 : 3'h0;
          end
          default: begin
            nxt_len  = nxt_ale_cyc ? ebt_pkg::LAT_BASE_CLKS + {1'b0, lat_read}
                                   : ebt_pkg::UNL_BASE_CLKS + {1'b0, unl_read};
            nxt_sbeg = nxt_ale_cyc ? nxt_alast + 3'h1 : 3'h0;
            nxt_send = nxt_len;
          end
        endcase
      end
      ebt_pkg::EBT_RUN: begin
        if (stall) begin
          nxt_cnt = cnt_ff;
        end else if (cnt_ff != len_ff - 3'h1) begin
          nxt_cnt = cnt_ff + 3'h1;
        end else if (pend_ff) begin
          // second byte: unlatched timing, strobe window starts at zero so it never lifts
          nxt_cnt     = 3'h0;
          nxt_pend    = 1'b0;
          nxt_second  = 1'b1;
          nxt_ale_cyc = 1'b0;
          nxt_len     = ebt_pkg::UNL_BASE_CLKS + {1'b0, unl_read};
          nxt_sbeg    = 3'h0;
          nxt_send    = nxt_len;
        end else begin
          nxt_st   = ebt_pkg::EBT_IDLE;
          nxt_done = 1'b1;
        end
      end
      default: nxt_st = ebt_pkg::EBT_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff      <= ebt_pkg::EBT_IDLE;
      cnt_ff     <= 3'h0;
      len_ff     <= 3'h0;
      sbeg_ff    <= 3'h0;
      send_ff    <= 3'h0;
      dbeg_ff    <= 3'h0;
      alast_ff   <= 3'h0;
      ale_cyc_ff <= 1'b0;
      second_ff  <= 1'b0;
      pend_ff    <= 1'b0;
      stall_ff   <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      cnt_ff     <= nxt_cnt;
      len_ff     <= nxt_len;
      sbeg_ff    <= nxt_sbeg;
      send_ff    <= nxt_send;
      dbeg_ff    <= nxt_dbeg;
      alast_ff   <= nxt_alast;
      ale_cyc_ff <= nxt_ale_cyc;
      second_ff  <= nxt_second;
      pend_ff    <= nxt_pend;
      stall_ff   <= stall;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drivers, registered from next state so each pin moves on a clock edge
  assign strobe_win = (nxt_st == ebt_pkg::EBT_RUN) && (nxt_cnt >= nxt_sbeg) && (nxt_cnt < nxt_send);

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_req_ready           <= 1'b1;
      o_cycle_done          <= 1'b0;
      ale_ff                <= 1'b0;
      o_code_fetch_strobe_n <= 1'b1;
      o_read_strobe_n       <= 1'b1;
      o_write_strobe_low_n  <= 1'b1;
      o_write_strobe_high_n <= 1'b1;
      o_wdata_oe_n          <= 1'b1;
      o_addr_a0             <= 1'b0;
    end else begin
      o_req_ready           <= (nxt_st == ebt_pkg::EBT_IDLE);
      o_cycle_done          <= nxt_done;
      ale_ff                <= (nxt_st == ebt_pkg::EBT_RUN) && nxt_ale_cyc && (nxt_cnt <= nxt_alast);
      o_code_fetch_strobe_n <= !(strobe_win && kind_ff == ebt_pkg::KIND_CODE);
      o_read_strobe_n       <= !(strobe_win && kind_ff == ebt_pkg::KIND_READ);
      o_write_strobe_low_n  <= !(strobe_win && kind_ff == ebt_pkg::KIND_WRITE && wr_lo_ff);
      o_write_strobe_high_n <= !(strobe_win && kind_ff == ebt_pkg::KIND_WRITE && wr_hi_ff);
      o_wdata_oe_n          <= !((nxt_st == ebt_pkg::EBT_RUN) && kind_ff == ebt_pkg::KIND_WRITE &&
                                 (nxt_cnt >= nxt_dbeg));
      o_addr_a0             <= (nxt_st == ebt_pkg::EBT_RUN) && nxt_second;
    end
  end

  // the latch pulse ends half a clock into its last clock, cut on the falling edge
  always_ff @(negedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) ale_cut_neg_ff <= 1'b0;
    else        ale_cut_neg_ff <= ale_ff && (cnt_ff == alast_ff);
  end

  // two flops meet here; the only way to get a half clock pulse from one clock
  assign o_addr_latch = ale_ff && !ale_cut_neg_ff;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  sequence run_start;
    st_ff == ebt_pkg::EBT_RUN && $past(st_ff) == ebt_pkg::EBT_SETUP;
  endsequence

  chk_code_len_lat: assert property (
    run_start and (kind_ff == ebt_pkg::KIND_CODE && ale_cyc_ff) |-> len_ff == 3'h2 + {1'b0, $past(lat_code)})
    else $error("latched fetch length wrong");
  chk_code_len_unl: assert property (
    run_start and (kind_ff == ebt_pkg::KIND_CODE && !ale_cyc_ff) |-> len_ff == 3'h1 + {1'b0, $past(unl_code)})
    else $error("unlatched fetch length wrong");
  chk_read_len_unl: assert property (
    run_start and (kind_ff == ebt_pkg::KIND_READ && !ale_cyc_ff)
      |-> len_ff == 3'h1 + {1'b0, $past(unl_read)} && !o_read_strobe_n)
    else $error("unlatched read length or strobe wrong");
  chk_read_len_lat: assert property (
    run_start and (kind_ff == ebt_pkg::KIND_READ && ale_cyc_ff) |-> len_ff == 3'h2 + {1'b0, $past(lat_read)})
    else $error("latched read length wrong");
  chk_ale_narrow: assert property (
    $rose(ale_ff) && alast_ff == 3'h0 |=> !ale_ff)
    else $error("narrow latch pulse too long");
  chk_ale_wide: assert property (
    $rose(ale_ff) && alast_ff == 3'h1 |=> ale_ff ##1 !ale_ff)
    else $error("wide latch pulse wrong");
  chk_read_after_ale: assert property (
    st_ff == ebt_pkg::EBT_RUN && kind_ff == ebt_pkg::KIND_READ && ale_cyc_ff && cnt_ff == alast_ff
      |-> o_read_strobe_n ##1 !o_read_strobe_n)
    else $error("read strobe not half clock after latch");
  chk_fetch_after_ale: assert property (
    st_ff == ebt_pkg::EBT_RUN && kind_ff == ebt_pkg::KIND_CODE && ale_cyc_ff && cnt_ff == alast_ff
      |-> o_code_fetch_strobe_n ##1 !o_code_fetch_strobe_n)
    else $error("fetch strobe not half clock after latch");
  chk_split_low: assert property (
    st_ff == ebt_pkg::EBT_RUN && pend_ff && !o_read_strobe_n |=> !o_read_strobe_n)
    else $error("read strobe lifted between bytes");
  chk_wr_width: assert property (
    run_start and (kind_ff == ebt_pkg::KIND_WRITE) |-> send_ff - sbeg_ff == ($past(wws) ? 3'h2 : 3'h1))
    else $error("write strobe width wrong");
  chk_wr_hold: assert property (
    run_start and (kind_ff == ebt_pkg::KIND_WRITE) |-> len_ff - send_ff == {2'h0, $past(whs)})
    else $error("write hold wrong");
  chk_wr_len_lat: assert property (
    run_start and (kind_ff == ebt_pkg::KIND_WRITE && ale_cyc_ff) |-> len_ff == 3'h2 + {1'b0, $past(lat_write)})
    else $error("latched write length wrong");
  chk_wr_len_unl: assert property (
    run_start and (kind_ff == ebt_pkg::KIND_WRITE && !ale_cyc_ff)
      |-> len_ff == 3'h2 + {1'b0, $past(unl_write)} && !o_wdata_oe_n)
    else $error("unlatched write length or data wrong");
  chk_wr_data_setup: assert property (
    st_ff == ebt_pkg::EBT_RUN && kind_ff == ebt_pkg::KIND_WRITE && ale_cyc_ff && cnt_ff == alast_ff
      |-> o_wdata_oe_n ##1 !o_wdata_oe_n)
    else $error("latched write data start wrong");
  chk_wait_holds: assert property (
    stall |=> cnt_ff == $past(cnt_ff) && $stable(o_read_strobe_n) && $stable(o_write_strobe_low_n))
    else $error("wait did not hold the cycle");

  cov_fetch_lat: cover property (run_start and (kind_ff == ebt_pkg::KIND_CODE && ale_cyc_ff));
  cov_split_read: cover property ($rose(o_addr_a0) && !o_read_strobe_n);
  cov_write_stall: cover property (stall && kind_ff == ebt_pkg::KIND_WRITE);
  cov_done: cover property (o_cycle_done);

endmodule : ebt_bus_timing

`default_nettype wire

// ===== ebt_bus_timing_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; $display("FAIL %0t %h %h", $time, a, b); end end
module ebt_bus_timing_bench;
  logic        clk = 1'h0, rstn = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic        rqv = 1'h0, lat = 1'h0, spl = 1'h0, whi = 1'h1;
  logic [3:0]  awa = 4'h0, ara = 4'h0, strb = 4'hf;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0]  kind = 2'h0, bresp, rresp;
  logic [2:0]  stall = 3'h0;
  logic        awr, wrdy, bv, arr, rv, rqr, done, wt, ale, cf_n, rd_n, wl_n, wh_n, oe_n, a0;
  int          fails = 0, n_checks = 0;
  always #4 clk = ~clk;
  ebt_bus_timing dut (.i_sys_clk(clk), .i_rstn(rstn), .i_axi_awaddr(awa), .i_axi_awvalid(awv),
    .o_axi_awready(awr), .i_axi_wdata(wd), .i_axi_wstrb(strb), .i_axi_wvalid(wv), .o_axi_wready(wrdy),
    .o_axi_bresp(bresp), .o_axi_bvalid(bv), .i_axi_bready(bry), .i_axi_araddr(ara), .i_axi_arvalid(arv),
    .o_axi_arready(arr), .o_axi_rdata(rdat), .o_axi_rresp(rresp), .o_axi_rvalid(rv), .i_axi_rready(rry),
    .i_req_valid(rqv), .o_req_ready(rqr), .i_req_kind(kind), .i_req_latched(lat), .i_req_split(spl),
    .i_req_wr_lo(1'h1), .i_req_wr_hi(whi), .o_cycle_done(done), .i_wait(wt), .o_addr_latch(ale),
    .o_code_fetch_strobe_n(cf_n), .o_read_strobe_n(rd_n), .o_write_strobe_low_n(wl_n),
    .o_write_strobe_high_n(wh_n), .o_wdata_oe_n(oe_n), .o_addr_a0(a0));
  ebt_mem_model mem (.i_clk(clk), .i_strobe_n(cf_n & rd_n & wl_n & wh_n), .i_addr_a0(a0), .i_stall(stall),
    .o_wait(wt));
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    int i = 0;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    do begin
      @(posedge clk);
      i++;
      if (awr) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
    end while (bv !== 1'h1 && i < 50);
    `CHK(bv, 1'h1)
    bry <= 1'h0;
    `CHK(bresp, r)
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    int i = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do begin
      @(posedge clk);
      i++;
      if (arr) arv <= 1'h0;
    end while (rv !== 1'h1 && i < 50);
    `CHK(rv, 1'h1)
    rry <= 1'h0;
    `CHK(rdat, {24'h0, d})
    `CHK(rresp, r)
  endtask : rd
  // counts in half clocks: strobe low, data held after strobe, latch high, data before strobe,
  // gap from latch end to strobe; four-state counters so an unknown pin cannot pass
  task automatic run(input logic [1:0] k, input logic l, s, input int e_st, e_ho, e_la, e_su, e_gp);
    integer st = 0, ho = 0, la = 0, hi = 0, su = 0, gp = 0, wh = 0;
    int     i;
    @(posedge clk);
    @(posedge clk);
    rqv <= 1'h1;
    kind <= k;
    lat <= l;
    spl <= s;
    @(posedge clk);
    `CHK(rqr, 1'h1)
    rqv <= 1'h0;
    for (i = 0; i < 200 && done !== 1'h1; i++) begin
      @(clk);
      #1;
      st += (k == 2'h0) ? !cf_n : (k == 2'h1) ? !rd_n : !(wl_n & wh_n);
      ho += (!oe_n && wl_n && st > 0);
      su += (!oe_n && st == 0);
      la += ale;
      gp += (la > 0 && !ale && st == 0);
      hi += a0;
      wh += !wh_n;
    end
    `CHK(done, 1'h1)
    `CHK(rqr, 1'h1)
    `CHK(st, e_st)
    `CHK(ho, e_ho)
    `CHK(la, e_la)
    `CHK(su, e_su)
    `CHK(gp, e_gp)
    `CHK(hi > 0, s)
    `CHK(wh > 0, k == 2'h2 && whi)
  endtask : run
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    fails++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    repeat (3) @(posedge clk);
    rd(4'h0, 8'h7f, 2'h0);
    rd(4'h4, 8'hff, 2'h0);
    rd(4'hc, 8'h00, 2'h2);
    wr(4'hc, 8'h00, 2'h2);
    strb <= 4'h0;
    wr(4'h0, 8'h00, 2'h0);
    strb <= 4'hf;
    rd(4'h0, 8'h7f, 2'h0);
    // every length code, narrow latch, write hold on as software must keep it
    for (int n = 0; n < 4; n++) begin
      wr(4'h4, 8'(8'h55 * n), 2'h0);
      wr(4'h0, 8'(8'h20 | (8'h05 * n)), 2'h0);
      rd(4'h0, 8'(8'h20 | (8'h05 * n)), 2'h0);
      run(2'h1, 1'h0, 1'h0, 2 * n + 2, 0, 0, 0, 0);
      run(2'h1, 1'h1, 1'h0, 2 * n + 2, 0, 1, 0, 1);
      run(2'h0, 1'h0, 1'h0, 2 * n + 2, 0, 0, 0, 0);
      run(2'h0, 1'h1, 1'h0, 2 * n + 2, 0, 1, 0, 1);
      run(2'h2, 1'h0, 1'h0, 2, 2, 0, 2 * n, 0);
      // the shortest latched write has negative setup, so software never asks for it
      if (n > 0) run(2'h2, 1'h1, 1'h0, 2, 2, 1, 2 * n - 2, 2 * n - 1);
    end
    run(2'h1, 1'h1, 1'h1, 16, 0, 1, 0, 1);
    wr(4'h0, 8'h7f, 2'h0);
    run(2'h0, 1'h1, 1'h0, 6, 0, 3, 0, 1);
    run(2'h2, 1'h0, 1'h0, 4, 2, 0, 4, 0);
    wr(4'h0, 8'h4f, 2'h0);
    run(2'h2, 1'h0, 1'h0, 4, 0, 0, 6, 0);
    whi <= 1'h0;
    run(2'h2, 1'h0, 1'h0, 4, 0, 0, 6, 0);
    whi <= 1'h1;
    stall <= 3'h2;
    run(2'h1, 1'h0, 1'h0, 12, 0, 0, 0, 0);
    run(2'h1, 1'h1, 1'h1, 24, 0, 1, 0, 1);
    test_done();
  end
endmodule : ebt_bus_timing_bench
`default_nettype wire

// ===== ebt_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ebt_mem_model (
  // clock
  input  wire logic       i_clk,
  // strobes seen from the bus, any low; low address bit of a split read
  input  wire logic       i_strobe_n,
  input  wire logic       i_addr_a0,
  // clocks of wait per strobe, 0 = fast memory
  input  wire logic [2:0] i_stall,
  // wait pin
  output var  logic       o_wait
);
  logic [2:0] cnt_ff;
  logic       a0_ff;
  logic       a0_rise;
  logic [2:0] base;
  // one strobe spans both bytes of a split read, so a rising a0 restarts the stretch
  // bursts are not modelled: every fetch has its own strobe edge to restart
  assign a0_rise = i_addr_a0 && !a0_ff;
  assign base    = a0_rise ? 3'h0 : cnt_ff;
  // slow memory holds wait for i_stall clocks from strobe start
  always_ff @(posedge i_clk) begin
    a0_ff  <= i_addr_a0;
    cnt_ff <= i_strobe_n ? 3'h0 : base + {2'h0, o_wait};
  end
  // wait drops between strobes, so no stale stretch leaks into the next cycle
  assign o_wait = !i_strobe_n && (base < i_stall);
endmodule : ebt_mem_model
`default_nettype wire

// ===== ebt_pkg.sv
package ebt_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the register bus
  localparam logic [3:0] REG_TIMING_LOW_OFF  = 4'h0;
  localparam logic [3:0] REG_TIMING_HIGH_OFF = 4'h4;
  localparam logic [3:0] REG_STATUS_OFF      = 4'h8;

  // bus_timing_low_reg fields
  localparam int unsigned FLD_UNL_CODE_LSB    = 0;
  localparam int unsigned FLD_LAT_CODE_LSB    = 2;
  localparam int unsigned FLD_LATCH_WIDTH_BIT = 4;
  localparam int unsigned FLD_WRITE_HOLD_BIT  = 5;
  localparam int unsigned FLD_WRITE_WIDTH_BIT = 6;

  // bus_timing_high_reg fields
  localparam int unsigned FLD_UNL_WRITE_LSB = 0;
  localparam int unsigned FLD_LAT_WRITE_LSB = 2;
  localparam int unsigned FLD_UNL_READ_LSB  = 4;
  localparam int unsigned FLD_LAT_READ_LSB  = 6;

  // reset values: longest cycles, wide latch pulse, write hold on
  localparam logic [7:0] TIMING_LOW_RST  = 8'h7f;
  localparam logic [7:0] TIMING_HIGH_RST = 8'hff;

  //////////////////////////////////////////////////////////////////////////////
  // cycle figures in whole clocks
  localparam logic [2:0] LAT_BASE_CLKS       = 3'h2;
  localparam logic [2:0] UNL_BASE_CLKS       = 3'h1;
  localparam logic [2:0] UNL_WRITE_BASE_CLKS = 3'h2;
  localparam logic [2:0] ALE_LAST_NARROW     = 3'h0;
  localparam logic [2:0] ALE_LAST_WIDE       = 3'h1;
  localparam logic [2:0] WR_WIDTH_NARROW     = 3'h1;
  localparam logic [2:0] WR_WIDTH_WIDE       = 3'h2;
  localparam logic [2:0] WR_HOLD_ON          = 3'h1;
  localparam logic [2:0] WR_HOLD_OFF         = 3'h0;
  localparam logic [2:0] RD_WAIT_LEAD        = 3'h2;
  localparam logic [2:0] WAIT_LEAD           = 3'h1;

  //////////////////////////////////////////////////////////////////////////////
  // request kinds and bus answers
  localparam logic [1:0] KIND_CODE   = 2'h0;
  localparam logic [1:0] KIND_READ   = 2'h1;
  localparam logic [1:0] KIND_WRITE  = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    EBT_IDLE  = 3'b001,
    EBT_SETUP = 3'b010,
    EBT_RUN   = 3'b100
  } ebt_state_e;

endpackage : ebt_pkg

// ===== ebt_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ebt_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // level in and out
  input  wire logic i_d,
  output var  logic o_q
);

  logic meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_ff <= RST_VAL;
      o_q     <= RST_VAL;
    end else begin
      meta_ff <= i_d;
      o_q     <= meta_ff;
    end
  end

endmodule : ebt_sync

`default_nettype wire
